// [src/ftf_fifo_flags.sv]
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Almost-full when gap >= threshold shifted eight.
// - Almost-empty when shifted threshold >= gap.
// - Active threshold bits: four plus log2 depth.
// - Clear empties FIFO, sets flag levels.
// - Read strobe when not empty presents next word.
// - Writes while full are refused but raise the overflow event.
// - Reads while empty are refused but raise the underflow event.
// - Write strobe stores word, advances write counters.
module ftf_fifo_flags
   import ftf_pkg::*;
#(
   parameter int DATA_W = 9,
   parameter int ADDR_W = 4,
   parameter int DEPTH_BLOCKS = 1
) (
   input wire logic sys_clk_in,
   input wire logic srst_in,
   // Avalon-MM slave.
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Stream side.
   input wire logic fifo_clear_in,
   input wire logic fifo_write_strobe_in,
   input wire logic [DATA_W-1:0] write_word_bus_in,
   input wire logic fifo_read_strobe_in,
   output logic [DATA_W-1:0] read_word_out,
   output logic full_out,
   output logic empty_out,
   output logic almost_full_flag_out,
   output logic almost_empty_flag_out,
   output logic irq_out
);
   import ftf_pkg::*;

   localparam int ACT_BITS = FTF_BASE_THR_BITS + $clog2(DEPTH_BLOCKS);
   localparam int CNT_W = ADDR_W + 1;
   localparam logic [CNT_W-1:0] CAPACITY = CNT_W'(1 << ADDR_W);
   localparam logic [FTF_THR_W-1:0] THR_MASK = FTF_THR_W'((1 << ACT_BITS) - 1);

   // Refuse shapes the counters and the threshold mask cannot serve.
   if (DEPTH_BLOCKS != 1 && DEPTH_BLOCKS != 2 && DEPTH_BLOCKS != 4 &&
       DEPTH_BLOCKS != 8 && DEPTH_BLOCKS != 16) begin : g_bad_depth
      $error("DEPTH_BLOCKS must be 1, 2, 4, 8 or 16");
   end
   if (ADDR_W < 1 || ADDR_W > 15 || DATA_W < 1 || DATA_W > 36) begin : g_bad_shape
      $error("ADDR_W must be 1..15 and DATA_W 1..36");
   end

   logic [ADDR_W-1:0] wr_idx_q, rd_idx_q;
   logic [CNT_W-1:0] count_q, count_d;
   logic [FTF_THR_W-1:0] af_thr_q, ae_thr_q;
   logic [FTF_IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set;
   logic [FTF_IRQ_W-1:0] irq_clr, irq_mask_d;
   logic clear_pulse_q, wait_q;
   logic do_write, do_read, clear_now, bus_req, bus_done;
   logic [FTF_GAP_W-1:0] gap_d, gap_q;
   logic af_d, ae_d;
   logic [31:0] rd_mux;

   // Bus request is answered on the second edge it is seen.
   assign bus_req = avs_read_in || avs_write_in;
   assign bus_done = bus_req && !wait_q;
   // Clear comes from either the user pin or the control register.
   assign clear_now = fifo_clear_in || clear_pulse_q;
   assign do_write = fifo_write_strobe_in && !full_out && !clear_now;
   assign do_read = fifo_read_strobe_in && !empty_out && !clear_now;

   // Occupancy follows accepted writes and reads; clear zeroes it.
   always_comb begin
      count_d = count_q;
      if (clear_now) begin
         count_d = '0;
      end else if (do_write && !do_read) begin
         count_d = count_q + CNT_W'(1);
      end else if (do_read && !do_write) begin
         count_d = count_q - CNT_W'(1);
      end
   end

   // Gap is zero extended; upper bits stay zero for small shapes.
   assign gap_d = FTF_GAP_W'(count_d);
   // Thresholds keep only the bits the cascade shape makes active.
   assign af_d = gap_d >= {af_thr_q & THR_MASK, 8'h00};
   assign ae_d = {ae_thr_q & THR_MASK, 8'h00} >= gap_d;

   // Write and read indices; clear returns both to the start.
   always_ff @(posedge sys_clk_in) begin
      if (srst_in || clear_now) begin
         wr_idx_q <= '0;
         rd_idx_q <= '0;
      end else begin
         if (do_write) begin
            wr_idx_q <= wr_idx_q + ADDR_W'(1);
         end
         if (do_read) begin
            rd_idx_q <= rd_idx_q + ADDR_W'(1);
         end
      end
   end

   // Flags are registered from the next occupancy so they match it.
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         count_q <= '0;
         gap_q <= '0;
         full_out <= 1'b0;
         empty_out <= 1'b1;
         almost_full_flag_out <= 1'b0;
         almost_empty_flag_out <= 1'b1;
      end else begin
         count_q <= count_d;
         gap_q <= gap_d;
         full_out <= !clear_now && count_d == CAPACITY;
         empty_out <= count_d == '0;
         // A zero threshold would raise almost-full on an empty FIFO,
         // so the clear cycle itself forces it low.
         almost_full_flag_out <= af_d && !clear_now;
         almost_empty_flag_out <= ae_d || clear_now;
      end
   end

   ftf_store #(
      .DATA_W(DATA_W),
      .ADDR_W(ADDR_W)
   ) u_store (
      .sys_clk_in(sys_clk_in),
      .wr_en_in(do_write),
      .wr_idx_in(wr_idx_q),
      .wr_data_in(write_word_bus_in),
      .rd_en_in(do_read),
      .rd_idx_in(rd_idx_q),
      .rd_data_out(read_word_out)
   );

   // Wait state: high while idle, low for the answering edge.
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         wait_q <= 1'b1;
      end else if (bus_req && wait_q) begin
         wait_q <= 1'b0;
      end else begin
         wait_q <= 1'b1;
      end
   end
   assign avs_waitrequest_out = wait_q;

   // Read multiplexer; unmapped offsets read as zero.
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (avs_address_in)
         FTF_OFS_THRESH: begin
            rd_mux[FTF_THR_AF_LSB +: FTF_THR_W] = af_thr_q;
            rd_mux[FTF_THR_AE_LSB +: FTF_THR_W] = ae_thr_q;
         end
         FTF_OFS_STATUS: begin
            rd_mux[FTF_ST_EMPTY] = empty_out;
            rd_mux[FTF_ST_FULL] = full_out;
            rd_mux[FTF_ST_AF] = almost_full_flag_out;
            rd_mux[FTF_ST_AE] = almost_empty_flag_out;
            rd_mux[FTF_ST_GAP_LSB +: FTF_GAP_W] = gap_q;
         end
         FTF_OFS_IRQ_STAT: rd_mux[FTF_IRQ_W-1:0] = irq_stat_q;
         FTF_OFS_IRQ_MASK: rd_mux[FTF_IRQ_W-1:0] = irq_mask_q;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data is loaded on the first edge so it stands at the answer.
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         avs_readdata_out <= 32'h0000_0000;
      end else if (avs_read_in && wait_q) begin
         avs_readdata_out <= rd_mux;
      end
   end

   // Threshold and mask registers honour byte enables.
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         af_thr_q <= FTF_THRESH_RST[FTF_THR_AF_LSB +: FTF_THR_W];
         ae_thr_q <= FTF_THRESH_RST[FTF_THR_AE_LSB +: FTF_THR_W];
         irq_mask_q <= FTF_IRQ_MASK_RST;
      end else if (bus_done && avs_write_in) begin
         if (avs_address_in == FTF_OFS_THRESH && avs_byteenable_in[0]) begin
            af_thr_q <= avs_writedata_in[FTF_THR_AF_LSB +: FTF_THR_W];
         end
         if (avs_address_in == FTF_OFS_THRESH && avs_byteenable_in[1]) begin
            ae_thr_q <= avs_writedata_in[FTF_THR_AE_LSB +: FTF_THR_W];
         end
         if (avs_address_in == FTF_OFS_IRQ_MASK && avs_byteenable_in[0]) begin
            irq_mask_q <= avs_writedata_in[FTF_IRQ_W-1:0];
         end
      end
   end

   // Clear from software is a one-cycle pulse after the accepted write.
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         clear_pulse_q <= 1'b0;
      end else begin
         clear_pulse_q <= bus_done && avs_write_in &&
            avs_address_in == FTF_OFS_CTRL && avs_byteenable_in[0] &&
            avs_writedata_in[FTF_CTRL_CLEAR];
      end
   end

   // Events: refused strobes and rising almost flags.
   always_comb begin
      irq_set = '0;
      irq_set[FTF_IRQ_OVERFLOW] = fifo_write_strobe_in && full_out &&
         !clear_now;
      irq_set[FTF_IRQ_UNDERFLOW] = fifo_read_strobe_in && empty_out &&
         !clear_now;
      irq_set[FTF_IRQ_AF_RISE] = af_d && !clear_now && !almost_full_flag_out;
      irq_set[FTF_IRQ_AE_RISE] = (ae_d || clear_now) &&
         !almost_empty_flag_out;
   end

   // Sticky status, write one to clear; a new event beats the clear.
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         irq_stat_q <= '0;
      end else if (bus_done && avs_write_in &&
                   avs_address_in == FTF_OFS_IRQ_STAT &&
                   avs_byteenable_in[0]) begin
         irq_stat_q <= (irq_stat_q & ~avs_writedata_in[FTF_IRQ_W-1:0]) |
            irq_set;
      end else begin
         irq_stat_q <= irq_stat_q | irq_set;
      end
   end

   // Clear pattern and next mask of this cycle, so the level output
   // follows a mask write on the same edge as the register does.
   assign irq_clr = (bus_done && avs_write_in &&
      avs_address_in == FTF_OFS_IRQ_STAT && avs_byteenable_in[0]) ?
      avs_writedata_in[FTF_IRQ_W-1:0] : '0;
   assign irq_mask_d = (bus_done && avs_write_in &&
      avs_address_in == FTF_OFS_IRQ_MASK && avs_byteenable_in[0]) ?
      avs_writedata_in[FTF_IRQ_W-1:0] : irq_mask_q;

   // Level interrupt, registered from the next status and mask.
   // Masked events must stay silent, so the mask covers new events too.
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_d);
      end
   end
endmodule
`default_nettype wire

// [src/ftf_pkg.sv]
package ftf_pkg;
   // Register byte offsets on the control bus.
   localparam logic [7:0] FTF_OFS_CTRL = 8'h00;
   localparam logic [7:0] FTF_OFS_THRESH = 8'h04;
   localparam logic [7:0] FTF_OFS_STATUS = 8'h08;
   localparam logic [7:0] FTF_OFS_IRQ_STAT = 8'h0C;
   localparam logic [7:0] FTF_OFS_IRQ_MASK = 8'h10;
   // Control register fields.
   localparam int FTF_CTRL_CLEAR = 0;
   // Threshold register fields.
   localparam int FTF_THR_AF_LSB = 0;
   localparam int FTF_THR_AE_LSB = 8;
   localparam int FTF_THR_W = 8;
   localparam logic [31:0] FTF_THRESH_RST = 32'h0000_0000;
   // Status register fields.
   localparam int FTF_ST_EMPTY = 0;
   localparam int FTF_ST_FULL = 1;
   localparam int FTF_ST_AF = 2;
   localparam int FTF_ST_AE = 3;
   localparam int FTF_ST_GAP_LSB = 16;
   // Interrupt event bits, shared by status and mask registers.
   localparam int FTF_IRQ_OVERFLOW = 0;
   localparam int FTF_IRQ_UNDERFLOW = 1;
   localparam int FTF_IRQ_AF_RISE = 2;
   localparam int FTF_IRQ_AE_RISE = 3;
   localparam int FTF_IRQ_W = 4;
   localparam logic [3:0] FTF_IRQ_MASK_RST = 4'h0;
   // Fill level gap width and base count of active threshold bits.
   localparam int FTF_GAP_W = 16;
   localparam int FTF_BASE_THR_BITS = 4;
endpackage

// [src/ftf_store.sv]
`timescale 1ns/10ps
`default_nettype none
module ftf_store #(
   parameter int DATA_W = 9,
   parameter int ADDR_W = 4
) (
   input wire logic sys_clk_in,
   input wire logic wr_en_in,
   input wire logic [ADDR_W-1:0] wr_idx_in,
   input wire logic [DATA_W-1:0] wr_data_in,
   input wire logic rd_en_in,
   input wire logic [ADDR_W-1:0] rd_idx_in,
   output logic [DATA_W-1:0] rd_data_out
);
   localparam int ENTRIES = 1 << ADDR_W;
   logic [DATA_W-1:0] mem_q [ENTRIES];

   // One flip-flop word per entry; contents need no reset.
   for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
      always_ff @(posedge sys_clk_in) begin
         if (wr_en_in && wr_idx_in == ADDR_W'(i)) begin
            mem_q[i] <= wr_data_in;
         end
      end
   end

   // Read word is registered so the output comes from a flip-flop.
   always_ff @(posedge sys_clk_in) begin
      if (rd_en_in) begin
         rd_data_out <= mem_q[rd_idx_in];
      end
   end
endmodule
`default_nettype wire

// [verif/ftf_flags_properties.sv]
`timescale 1ns/10ps
`default_nettype none
// Pin-level checks; thresholds are internal, so flags are checked as they
// move with occupancy while no bus write can change a threshold.
module ftf_flags_chk (
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire logic fifo_clear_in,
   input wire logic fifo_write_strobe_in,
   input wire logic fifo_read_strobe_in,
   input wire logic full_out,
   input wire logic empty_out,
   input wire logic almost_full_flag_out,
   input wire logic almost_empty_flag_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);
   // An accepted bus write may move a threshold or fire the software clear.
   logic bus_wr;
   assign bus_wr = avs_write_in && !avs_waitrequest_out;
   // A bus request is answered after exactly one wait cycle.
   sequence s_req;
      (avs_read_in || avs_write_in) && avs_waitrequest_out;
   endsequence
   sequence s_ack;
      !avs_waitrequest_out ##1 avs_waitrequest_out;
   endsequence
   chk_bus_one_wait: assert property (s_req |=> s_ack)
      else $error("bus answer not after one wait");
   chk_unmapped_zero: assert property (avs_read_in && avs_waitrequest_out
      && avs_address_in >= 8'h14 |=> avs_readdata_out == 32'h0000_0000)
      else $error("unmapped read not zero");
   chk_full_refuse: assert property (full_out && fifo_write_strobe_in
      && !fifo_read_strobe_in && !fifo_clear_in && !$past(bus_wr)
      |=> full_out)
      else $error("write left full state");
   chk_empty_refuse: assert property (empty_out && fifo_read_strobe_in
      && !fifo_write_strobe_in && !fifo_clear_in |=> empty_out)
      else $error("read left empty state");
   chk_write_fills: assert property (empty_out && fifo_write_strobe_in
      && !fifo_clear_in && !$past(bus_wr) |=> !empty_out)
      else $error("write not stored");
   chk_clear_state: assert property (fifo_clear_in |=> empty_out &&
      !full_out && !almost_full_flag_out && almost_empty_flag_out)
      else $error("clear did not empty");
   chk_af_holds: assert property (almost_full_flag_out &&
      fifo_write_strobe_in && !fifo_read_strobe_in && !fifo_clear_in &&
      !bus_wr && !$past(bus_wr) |=> almost_full_flag_out)
      else $error("almost-full dropped on a write");
   chk_ae_holds: assert property (almost_empty_flag_out &&
      fifo_read_strobe_in && !fifo_write_strobe_in &&
      !bus_wr && !$past(bus_wr) |=> almost_empty_flag_out)
      else $error("almost-empty dropped on a read");
   chk_empty_near: assert property (empty_out |->
      almost_empty_flag_out)
      else $error("empty without almost-empty");
   chk_never_both: assert property (!(empty_out && full_out))
      else $error("empty and full together");
endmodule
bind ftf_fifo_flags ftf_flags_chk i_ftf_flags_chk (
   .sys_clk_in(sys_clk_in), .srst_in(srst_in),
   .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out), .fifo_clear_in(fifo_clear_in),
   .fifo_write_strobe_in(fifo_write_strobe_in),
   .fifo_read_strobe_in(fifo_read_strobe_in), .full_out(full_out),
   .empty_out(empty_out), .almost_full_flag_out(almost_full_flag_out),
   .almost_empty_flag_out(almost_empty_flag_out));
`default_nettype wire

// [verif/ftf_user_model.sv]
`timescale 1ns/10ps
`default_nettype none
module ftf_user_model #(
   parameter int DATA_W = 9
) (
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic push_in,
   input wire logic pop_in,
   input wire logic clear_in,
   input wire logic full_in,
   output logic fifo_write_strobe_out,
   output logic fifo_read_strobe_out,
   output logic fifo_clear_out,
   output logic [DATA_W-1:0] word_out
);
   logic [DATA_W-1:0] seq_q;
   // Idle data is inverted so a stale word can never pass for a fresh one.
   assign fifo_write_strobe_out = push_in;
   assign fifo_read_strobe_out = pop_in;
   assign fifo_clear_out = clear_in;
   assign word_out = push_in ? seq_q : ~seq_q;
   // A refused word is offered again, so the sequence moves on acceptance.
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         seq_q <= DATA_W'(9'h1C5);
      end else if (push_in && !full_in && !clear_in) begin
         seq_q <= seq_q + 1'b1;
      end
   end
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import ftf_pkg::*;
   typedef struct {logic [7:0] taf; logic [7:0] tae; int n; logic af;
      logic ae;} ftf_row_t;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic push = 1'b0;
   logic pop = 1'b0;
   logic clr = 1'b0;
   logic mon = 1'b0;
   logic rd_ok = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0000_0000;
   logic [31:0] rv;
   logic [8:0] exp_rd;
   logic [8:0] nxt = 9'h1C5;
   logic [8:0] q[$];
   wire logic ws, rs, cs, full, empty, af, ae, irq, wreq;
   wire logic [8:0] wword, rword;
   wire logic [31:0] rdata;
   int err_total = 0;
   int n_tests = 0;
   // Upper threshold bits beyond the four active ones must be ignored.
   ftf_row_t rows[5] = '{'{8'h00, 8'h00, 0, 1'b1, 1'b1},
      '{8'h00, 8'h00, 3, 1'b1, 1'b0}, '{8'h10, 8'h10, 5, 1'b1, 1'b0},
      '{8'h01, 8'h01, 9, 1'b0, 1'b1}, '{8'h0F, 8'h0F, 16, 1'b0, 1'b1}};
   ftf_user_model #(.DATA_W(9)) i_ftf_user_model (.sys_clk_in(clk),
      .srst_in(srst), .push_in(push), .pop_in(pop), .clear_in(clr),
      .full_in(full), .fifo_write_strobe_out(ws), .fifo_read_strobe_out(rs),
      .fifo_clear_out(cs), .word_out(wword));
   ftf_fifo_flags i_ftf_fifo_flags (.sys_clk_in(clk), .srst_in(srst),
      .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wd), .avs_byteenable_in(4'h3),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
      .fifo_clear_in(cs), .fifo_write_strobe_in(ws),
      .write_word_bus_in(wword), .fifo_read_strobe_in(rs),
      .read_word_out(rword), .full_out(full), .empty_out(empty),
      .almost_full_flag_out(af), .almost_empty_flag_out(ae), .irq_out(irq));
   always #25 clk = ~clk;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Holds the request until waitrequest is seen low at a rising edge.
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      // Only the watchdog ends a wait that never sees waitrequest low.
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      r = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // One stream cycle; the queue mirrors what the block should hold.
   task automatic cyc(input logic w, input logic r, input logic c);
      int sz;
      push <= w;
      pop <= r;
      clr <= c;
      @(posedge clk);
      sz = q.size();
      if (c) begin
         q.delete();
         rd_ok = 1'b0;
      end else begin
         if (r && sz > 0) begin
            exp_rd = q.pop_front();
            rd_ok = 1'b1;
         end
         if (w && sz < 16) begin
            q.push_back(nxt);
            nxt++;
         end
      end
   endtask
   task automatic regs0();
      logic [7:0] ofs[4] = '{FTF_OFS_THRESH, FTF_OFS_IRQ_MASK,
         FTF_OFS_IRQ_STAT, 8'h20};
      logic [31:0] r;
      logic [31:0] e;
      foreach (ofs[k]) begin
         bus(1'b0, ofs[k], 32'h0000_0000, r);
         // Zero thresholds raise almost-full on the first free edge.
         e = (ofs[k] == FTF_OFS_IRQ_STAT) ? 32'(1 << FTF_IRQ_AF_RISE) :
            32'h0000_0000;
         chk(r, e);
      end
   endtask
   // Stream outputs are compared half a cycle after each edge.
   always @(negedge clk) begin
      if (mon) begin
         chk(empty, q.size() == 0);
         chk(full, q.size() == 16);
         if (rd_ok) chk(rword, exp_rd);
      end
   end
   // Watchdog sized well above the few hundred cycles the run needs.
   initial begin
      #(5000 * 50);
      err_total++;
      stop_test();
   end
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      regs0();
      mon = 1'b1;
      foreach (rows[i]) begin
         cyc(1'b0, 1'b0, 1'b1);
         bus(1'b1, FTF_OFS_THRESH, {16'h0, rows[i].tae, rows[i].taf}, rv);
         repeat (rows[i].n) cyc(1'b1, 1'b0, 1'b0);
         cyc(1'b0, 1'b0, 1'b0);
         bus(1'b0, FTF_OFS_STATUS, 32'h0000_0000, rv);
         chk(rv, {16'(rows[i].n), 12'h000, rows[i].ae, rows[i].af,
            1'(rows[i].n == 16), 1'(rows[i].n == 0)});
         chk(af, rows[i].af);
         chk(ae, rows[i].ae);
      end
      $display("threshold table done");
      bus(1'b1, FTF_OFS_IRQ_STAT, 32'h0000_000F, rv);
      bus(1'b1, FTF_OFS_IRQ_MASK, 32'h0000_0001, rv);
      cyc(1'b1, 1'b0, 1'b0);
      cyc(1'b1, 1'b1, 1'b0);
      cyc(1'b0, 1'b0, 1'b0);
      bus(1'b0, FTF_OFS_IRQ_STAT, 32'h0000_0000, rv);
      chk(rv, 32'h0000_0001);
      @(negedge clk);
      chk(irq, 1'b1);
      bus(1'b1, FTF_OFS_IRQ_MASK, 32'h0000_0000, rv);
      @(negedge clk);
      chk(irq, 1'b0);
      bus(1'b1, FTF_OFS_IRQ_STAT, 32'h0000_0001, rv);
      bus(1'b0, FTF_OFS_IRQ_STAT, 32'h0000_0000, rv);
      chk(rv, 32'h0000_0000);
      $display("overflow test done");
      repeat (15) cyc(1'b0, 1'b1, 1'b0);
      cyc(1'b0, 1'b1, 1'b0);
      cyc(1'b0, 1'b0, 1'b0);
      bus(1'b0, FTF_OFS_IRQ_STAT, 32'h0000_0000, rv);
      chk(rv, 32'h0000_0002);
      $display("drain test done");
      repeat (3) cyc(1'b1, 1'b0, 1'b0);
      cyc(1'b0, 1'b0, 1'b0);
      // Software clear lands one edge after the write; mute the monitor.
      mon = 1'b0;
      bus(1'b1, FTF_OFS_CTRL, 32'h0000_0001, rv);
      @(posedge clk);
      q.delete();
      mon = 1'b1;
      bus(1'b0, FTF_OFS_STATUS, 32'h0000_0000, rv);
      chk(rv, 32'h0000_0009);
      $display("software clear done");
      mon = 1'b0;
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      q.delete();
      rd_ok = 1'b0;
      nxt = 9'h1C5;
      mon = 1'b1;
      @(negedge clk);
      chk(ae, 1'b1);
      chk(irq, 1'b0);
      regs0();
      $display("reset test done");
      stop_test();
   end
endmodule
`default_nettype wire
